// ==== ffmd_map.svh ====
// Register offsets, field positions and reset values of the freefall/motion detector.
// Included by the detector module; holds definitions only.
`ifndef FFMD_MAP_SVH
`define FFMD_MAP_SVH

`define FFMD_ADDR_COMMON_THS   8'h17
`define FFMD_ADDR_AXIS_THS_LO  8'h73
`define FFMD_ADDR_AXIS_THS_HI  8'h78
`define FFMD_ADDR_CFG          8'h1a
`define FFMD_ADDR_SRC          8'h1b
`define FFMD_ADDR_DBCOUNT      8'h1c
`define FFMD_ADDR_CTRL         8'h1d

// Configuration register fields
`define FFMD_CFG_LATCH_BIT     7
`define FFMD_CFG_HIGHG_BIT     6
`define FFMD_CFG_ZEN_BIT       5
`define FFMD_CFG_YEN_BIT       4
`define FFMD_CFG_XEN_BIT       3

// Common threshold fields
`define FFMD_THS_DBMODE_BIT    7
`define FFMD_THS_VALUE_MSB     6

// Per-axis high byte fields
`define FFMD_AXIS_EN_BIT       7
`define FFMD_AXIS_HI_MSB       4

// Source register fields
`define FFMD_SRC_EA_BIT        7

// Control register fields
`define FFMD_CTRL_ACTIVE_BIT   0

`define FFMD_RESET_BYTE        8'h00

`endif

// ==== ffmd_pkg.sv ====
// Types shared by the freefall/motion detector and its bench.
// Assumes 14-bit two's complement samples on three axes.
`default_nettype none

package ffmd_pkg;

  typedef logic [13:0] ffmd_axis_t;

  typedef struct packed {
    ffmd_axis_t [2:0] axis;
  } ffmd_sample_t;

  typedef enum logic {
    FFMD_LOW_G,
    FFMD_HIGH_G
  } ffmd_mode_t;

endpackage

`default_nettype wire

// ==== ffmd_detector.sv ====
// Freefall (low-g) and motion (high-g) event detector with its register file.
// Assumes a simple synchronous register port and one sample strobe per output-data-rate sample.
`default_nettype none
`include "ffmd_map.svh"

// Functional notes
// R1: With high-g select clear, the event needs the low-g condition on every enabled axis at once.
// R2: With high-g select set, the high-g condition on any one enabled axis suffices.
// R3: With latch enable set, the event flag holds until software reads the source register.
// R4: With latch enable clear, the event flag follows the present detection result per sample.
// R5: The debounce-mode bit of the common threshold register picks how the debounce counter filters.
// R6: Separate enables include or exclude the X, Y and Z axes.
// R7: With per-axis thresholds off, all axes use the 7-bit common threshold at address 17h.
// R8: With per-axis thresholds on, each axis uses its own 13-bit threshold held at 73h to 78h.
// R9: Freefall is magnitude at or below threshold for the debounce duration.
// R10: Motion is magnitude above threshold for the debounce duration.
// R11: For high-g events the source register reports which axes triggered and their direction; freefall events leave the axis bits zero.
// R12: Detection runs only in active mode; registers stay accessible in standby.
// R13: Comparison and debounce run once per new sample on the absolute value of each axis.
// R14: The common threshold compares against the magnitude upper bits, one count per 128 sample counts.
module ffmd_detector (
  input  wire logic               CLOCK_I,
  input  wire logic               RESET_I,
  input  wire logic [7:0]         REG_ADDR_I,
  input  wire logic [7:0]         REG_WDATA_I,
  input  wire logic               REG_WR_I,
  input  wire logic               REG_RD_I,
  output logic      [7:0]         REG_RDATA_O,
  input  wire logic               SAMPLE_VALID_I,
  input  wire ffmd_pkg::ffmd_sample_t SAMPLE_I,
  output logic                    EVENT_ACTIVE_O
);

  function automatic logic [13:0] magnitude(input logic [13:0] s);
    magnitude = s[13] ? 14'(~s + 14'h0001) : s;
  endfunction

  logic [7:0]  common_ths_reg;
  logic [7:0]  common_ths_next;
  logic [7:0]  cfg_reg;
  logic [7:0]  cfg_next;
  logic [7:0]  dbcount_reg;
  logic [7:0]  dbcount_next;
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [7:0]  thr_hi_reg [3];
  logic [7:0]  thr_hi_next [3];
  logic [7:0]  thr_lo_reg [3];
  logic [7:0]  thr_lo_next [3];
  logic [7:0]  cnt_reg;
  logic [7:0]  cnt_next;
  logic        det_reg;
  logic        det_next;
  logic        ea_reg;
  logic        ea_next;
  logic [5:0]  axis_src_reg;
  logic [5:0]  axis_src_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;

  logic [2:0]  axis_high;
  logic [2:0]  axis_low;
  logic [2:0]  axis_en;
  logic [5:0]  axis_flags;
  logic        any_en;
  logic        cond;
  logic        active;
  logic        per_axis;
  logic        src_read;
  ffmd_pkg::ffmd_mode_t mode;

  assign active   = ctrl_reg[`FFMD_CTRL_ACTIVE_BIT];
  assign per_axis = thr_hi_reg[0][`FFMD_AXIS_EN_BIT];
  assign axis_en  = {cfg_reg[`FFMD_CFG_ZEN_BIT], cfg_reg[`FFMD_CFG_YEN_BIT], cfg_reg[`FFMD_CFG_XEN_BIT]}; // [R6]
  assign mode     = cfg_reg[`FFMD_CFG_HIGHG_BIT] ? ffmd_pkg::FFMD_HIGH_G : ffmd_pkg::FFMD_LOW_G;
  assign src_read = REG_RD_I && (REG_ADDR_I == `FFMD_ADDR_SRC);

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_axis
      logic [13:0] mag;
      logic [13:0] thr;
      assign mag = magnitude(SAMPLE_I.axis[g]); // [R13]
      assign thr = per_axis ? {1'b0, thr_hi_reg[g][`FFMD_AXIS_HI_MSB:0], thr_lo_reg[g]} // [R8]
                            : {common_ths_reg[`FFMD_THS_VALUE_MSB:0], 7'h00};          // [R7] [R14]
      assign axis_high[g] = axis_en[g] && (mag > thr);          // [R10]
      assign axis_low[g]  = !axis_en[g] || (mag <= thr);        // [R9]
      // Event flag then sign, per axis
      assign axis_flags[2 * g + 1] = axis_high[g];
      assign axis_flags[2 * g]     = axis_high[g] && SAMPLE_I.axis[g][13]; // [R11]
    end
  endgenerate

  assign any_en = |axis_en;
  assign cond   = (mode == ffmd_pkg::FFMD_HIGH_G) ? |axis_high           // [R2]
                                                  : (any_en && &axis_low); // [R1]

  // Register file writes
  always_comb
  begin
    common_ths_next = common_ths_reg;
    cfg_next        = cfg_reg;
    dbcount_next    = dbcount_reg;
    ctrl_next       = ctrl_reg;
    for (int i = 0; i < 3; i++)
    begin
      thr_hi_next[i] = thr_hi_reg[i];
      thr_lo_next[i] = thr_lo_reg[i];
    end
    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        `FFMD_ADDR_COMMON_THS: common_ths_next = REG_WDATA_I;
        `FFMD_ADDR_CFG:        cfg_next        = REG_WDATA_I;
        `FFMD_ADDR_DBCOUNT:    dbcount_next    = REG_WDATA_I;
        `FFMD_ADDR_CTRL:       ctrl_next       = REG_WDATA_I;
        default:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (REG_ADDR_I == 8'(`FFMD_ADDR_AXIS_THS_LO + 2 * i))
              thr_hi_next[i] = REG_WDATA_I;
            if (REG_ADDR_I == 8'(`FFMD_ADDR_AXIS_THS_LO + 2 * i + 1))
              thr_lo_next[i] = REG_WDATA_I;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      common_ths_reg <= `FFMD_RESET_BYTE;
      cfg_reg        <= `FFMD_RESET_BYTE;
      dbcount_reg    <= `FFMD_RESET_BYTE;
      ctrl_reg       <= `FFMD_RESET_BYTE;
      for (int i = 0; i < 3; i++)
      begin
        thr_hi_reg[i] <= `FFMD_RESET_BYTE;
        thr_lo_reg[i] <= `FFMD_RESET_BYTE;
      end
    end
    else
    begin
      common_ths_reg <= common_ths_next;
      cfg_reg        <= cfg_next;
      dbcount_reg    <= dbcount_next;
      ctrl_reg       <= ctrl_next;
      for (int i = 0; i < 3; i++)
      begin
        thr_hi_reg[i] <= thr_hi_next[i];
        thr_lo_reg[i] <= thr_lo_next[i];
      end
    end
  end

  // Debounce, event flag and source capture
  always_comb
  begin
    cnt_next      = cnt_reg;
    det_next      = det_reg;
    ea_next       = ea_reg;
    axis_src_next = axis_src_reg;
    if (!active)
    begin
      cnt_next = 8'h00; // [R12]
      det_next = 1'b0;
    end
    else if (SAMPLE_VALID_I) // [R13]
    begin
      if (cond)
        cnt_next = (cnt_reg < dbcount_reg) ? 8'(cnt_reg + 8'h01) : cnt_reg;
      else if (common_ths_reg[`FFMD_THS_DBMODE_BIT])
        cnt_next = 8'h00;                                          // [R5]
      else
        cnt_next = (cnt_reg != 8'h00) ? 8'(cnt_reg - 8'h01) : 8'h00; // [R5]
      det_next = cond && (cnt_next >= dbcount_reg);                // [R9] [R10]
    end
    if (cfg_reg[`FFMD_CFG_LATCH_BIT])
    begin
      if (src_read)
      begin
        ea_next       = 1'b0;                                      // [R3]
        axis_src_next = 6'h00;
      end
      // Only a fresh sample sets; a held result must not re-arm after a read
      if (det_next && SAMPLE_VALID_I && (!ea_reg || src_read))
        axis_src_next = axis_flags;                                // [R11]
      if (det_next && SAMPLE_VALID_I)
        ea_next = 1'b1;                                            // [R3]
    end
    else
    begin
      ea_next = det_next;                                          // [R4]
      // Axis bits only from the sample that is being judged
      if (det_next && SAMPLE_VALID_I)
        axis_src_next = axis_flags;                                // [R11]
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      cnt_reg      <= 8'h00;
      det_reg      <= 1'b0;
      ea_reg       <= 1'b0;
      axis_src_reg <= 6'h00;
    end
    else
    begin
      cnt_reg      <= cnt_next;
      det_reg      <= det_next;
      ea_reg       <= ea_next;
      axis_src_reg <= axis_src_next;
    end
  end

  // Registered read data
  always_comb
  begin
    rdata_next = rdata_reg;
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        `FFMD_ADDR_COMMON_THS: rdata_next = common_ths_reg;
        `FFMD_ADDR_CFG:        rdata_next = cfg_reg;
        `FFMD_ADDR_DBCOUNT:    rdata_next = dbcount_reg;
        `FFMD_ADDR_CTRL:       rdata_next = ctrl_reg;
        `FFMD_ADDR_SRC:        rdata_next = {ea_reg, 1'b0, axis_src_reg}; // [R11]
        default:
        begin
          rdata_next = 8'h00;
          for (int i = 0; i < 3; i++)
          begin
            if (REG_ADDR_I == 8'(`FFMD_ADDR_AXIS_THS_LO + 2 * i))
              rdata_next = thr_hi_reg[i];
            if (REG_ADDR_I == 8'(`FFMD_ADDR_AXIS_THS_LO + 2 * i + 1))
              rdata_next = thr_lo_reg[i];
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign REG_RDATA_O    = rdata_reg;
  assign EVENT_ACTIVE_O = ea_reg;

endmodule

`default_nettype wire

// ==== ffmd_detector_properties.sv ====
// Port-level checker for ffmd_detector.
// Assumes one clock and a synchronous active-high reset; bound at the foot of this file.
`default_nettype none
module ffmd_detector_properties (
  input wire logic       CLOCK_I,
  input wire logic       RESET_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic       SAMPLE_VALID_I,
  input wire logic       EVENT_ACTIVE_O
);
  logic      act_reg;
  logic      act_next;
  wire logic src_rd = REG_RD_I && REG_ADDR_I == 8'h1b;
  // Shadow of the active bit
  always_comb
  begin
    act_next = act_reg;
    if (REG_WR_I && REG_ADDR_I == 8'h1d)
      act_next = REG_WDATA_I[0];
  end
  always_ff @(posedge CLOCK_I)
    act_reg <= RESET_I ? 1'b0 : act_next;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  AST_RISE_ON_SAMPLE: assert property ($rose(EVENT_ACTIVE_O) |-> $past(SAMPLE_VALID_I))
    else $error("flag rose without a sample");
  AST_STANDBY: assert property ($rose(EVENT_ACTIVE_O) |-> $past(act_reg))
    else $error("flag rose in standby");
  // Standby or config write drops the flag one cycle after the write edge
  AST_FALL_CAUSE: assert property ($fell(EVENT_ACTIVE_O)
    |-> $past(SAMPLE_VALID_I || REG_RD_I || REG_WR_I) || $past(REG_WR_I, 2))
    else $error("flag fell without cause");
  AST_SRC_EA: assert property (src_rd |=> REG_RDATA_O[7] == $past(EVENT_ACTIVE_O))
    else $error("source bit 7 differs from flag");
  AST_SRC_RSVD: assert property (src_rd |=> !REG_RDATA_O[6])
    else $error("source bit 6 set");
  AST_UNMAPPED: assert property (REG_RD_I && REG_ADDR_I == 8'h00 |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  AST_THS_RB: assert property (REG_WR_I && REG_ADDR_I == 8'h17 ##1 !REG_WR_I ##1 REG_RD_I && REG_ADDR_I == 8'h17
    |=> REG_RDATA_O == $past(REG_WDATA_I, 3)) else $error("threshold readback wrong");
  AST_RDATA_HOLD: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved without read");
endmodule
bind ffmd_detector ffmd_detector_properties i_ffmd_detector_properties (.CLOCK_I, .RESET_I, .REG_ADDR_I,
  .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .SAMPLE_VALID_I, .EVENT_ACTIVE_O);
`default_nettype wire

// ==== ffmd_host_model.sv ====
// Host side of the register port: one-cycle read and write strobes.
// Assumes the bench calls its tasks just after a rising clock edge.
`default_nettype none
module ffmd_host_model (
  input  wire logic       CLOCK_I,
  input  wire logic [7:0] RDATA_I,
  output var  logic [7:0] ADDR_O,
  output var  logic [7:0] WDATA_O,
  output var  logic       WR_O,
  output var  logic       RD_O
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ADDR_O, WDATA_O, WR_O, RD_O} = 18'h0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK_I) #2;
    {ADDR_O, WDATA_O, WR_O} = {a, d, 1'b1};
    @(posedge CLOCK_I) #2;
    // Released lines show the inverse
    {ADDR_O, WDATA_O, WR_O} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLOCK_I) #2;
    {ADDR_O, RD_O} = {a, 1'b1};
    @(posedge CLOCK_I) #2;
    {ADDR_O, RD_O} = {~a, 1'b0};
    d = RDATA_I;
  endtask
endmodule
`default_nettype wire

// ==== freefall_motion_detector_tb.sv ====
// Self-checking bench: random configs and samples against an integer model.
// Assumes ffmd_host_model drives the register port.
`default_nettype none
module freefall_motion_detector_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   sv  = 1'b0;
  logic                   wr, rd, ea;
  logic [7:0]             addr, wdata, rdata, rb;
  ffmd_pkg::ffmd_sample_t smp = '0;
  int                     n_errors = 0, comparisons = 0, seed = 4;
  int                     cfg, ths, dbc, cnt, flag, per, src;
  int                     thx[3];
  always #25 clk = ~clk;
  ffmd_detector i_ffmd_detector (.CLOCK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .SAMPLE_VALID_I(sv), .SAMPLE_I(smp), .EVENT_ACTIVE_O(ea));
  ffmd_host_model i_ffmd_host_model (.CLOCK_I(clk), .RDATA_I(rdata), .ADDR_O(addr), .WDATA_O(wdata),
    .WR_O(wr), .RD_O(rd));
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    check_byte({7'h0, got}, {7'h0, exp});
  endtask
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic sample;
    int s[3];
    int m, t, en, hi, lo, det, f;
    f = 0;
    en = 0;
    hi = 0;
    lo = 1;
    for (int a = 0; a < 3; a++)
    begin
      s[a] = $random(seed) % 2048;
      smp.axis[a] = 14'(s[a]);
      m = s[a] < 0 ? -s[a] : s[a];
      t = per ? thx[a] : (ths & 127) * 128;
      if (cfg[3 + a])
      begin
        en = 1;
        hi |= m > t;
        lo &= m <= t;
      end
      // Axis event bit, then sign bit
      if (cfg[3 + a] && m > t)
        f |= (s[a] < 0 ? 3 : 2) << (2 * a);
    end
    det = cfg[6] ? hi : en & lo;
    cnt = det ? (cnt < dbc ? cnt + 1 : dbc) : (ths[7] ? 0 : (cnt > 0 ? cnt - 1 : 0));
    det = det && cnt >= dbc;
    // Latched source keeps the first event until read
    if (det && !(cfg[7] && flag))
      src = f;
    flag = cfg[7] ? flag | det : det;
    @(posedge clk) #2;
    sv = 1'b1;
    @(posedge clk) #2;
    sv = 1'b0;
    check_flag(ea, flag[0]);
  endtask
  task automatic src_read;
    i_ffmd_host_model.rd(8'h1b, rb);
    check_flag(rb[7], flag[0]);
    check_byte({1'b0, rb[6:0]}, {2'b00, 6'(src)});
    if (cfg[7])
    begin
      flag = 0;
      src = 0;
    end
    check_flag(ea, flag[0]);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    i_ffmd_host_model.rd(8'h00, rb);
    check_byte(rb, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      cfg = 8'h08 | ($random(seed) & 8'hf8);
      ths = $random(seed) & 8'h8f;
      dbc = k % 3;
      per = k > 5;
      i_ffmd_host_model.wr(8'h1d, 8'h00);
      i_ffmd_host_model.wr(8'h1a, 8'(cfg));
      i_ffmd_host_model.wr(8'h17, 8'(ths));
      i_ffmd_host_model.rd(8'h17, rb);
      check_byte(rb, 8'(ths));
      i_ffmd_host_model.wr(8'h1c, 8'(dbc));
      for (int a = 0; a < 3; a++)
      begin
        thx[a] = $random(seed) & 2047;
        i_ffmd_host_model.wr(8'(8'h73 + 2 * a), {per[0], 2'b00, 5'(thx[a] >> 8)});
        i_ffmd_host_model.wr(8'(8'h74 + 2 * a), 8'(thx[a]));
      end
      i_ffmd_host_model.rd(8'h1b, rb);
      // Read clears latched axis bits; unlatched ones carry over
      if (cfg[7])
        src = 0;
      i_ffmd_host_model.wr(8'h1d, 8'h01);
      cnt = 0;
      flag = 0;
      repeat (40)
      begin
        sample();
        if ($random(seed) % 4 == 0)
          src_read();
      end
      $display("test %0d done cfg %h ths %h", k, cfg, ths);
    end
    conclude();
  end
endmodule
`default_nettype wire
